// file: hw/mpm_pkg.sv
package mpm_pkg;

    // Software port
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  OFF_FUNC_REQ  = 8'h00;
    localparam logic [7:0]  OFF_IRQ_REQ   = 8'h04;
    localparam logic [7:0]  OFF_PORT_DIR  = 8'h08;
    localparam logic [7:0]  OFF_PORT_OUT  = 8'h0C;
    localparam logic [7:0]  OFF_FUNC_REF  = 8'h10;
    localparam logic [7:0]  OFF_IRQ_REF   = 8'h14;
    localparam logic [7:0]  OFF_COMMAND   = 8'h18;
    localparam logic [7:0]  OFF_PIN_STAT  = 8'h1C;

    // Function enable bit positions
    localparam int FUNC_W     = 19;
    localparam int F_MANCH0   = 0;
    localparam int F_MANCH1   = 1;
    localparam int F_MANCH2   = 2;
    localparam int F_SPI      = 3;
    localparam int F_I2C      = 4;
    localparam int F_JTAG     = 5;
    localparam int F_SQW      = 6;
    localparam int F_SYSTEM_CLOCK_OUT_PIN     = 7;
    localparam int F_T2OUT    = 8;
    localparam int F_T2GATE   = 9;
    localparam int F_PULSE1   = 10;
    localparam int F_PULSE2   = 11;
    localparam int F_U0REN    = 12;
    localparam int F_U1REN    = 13;
    localparam int F_U0FULL   = 14;
    localparam int F_U1FULL   = 15;
    localparam int F_TBB_IN   = 16;
    localparam int F_TBA_USE  = 17;
    localparam int F_RESET_PIN_DISABLE     = 18;

    // External interrupt lines
    localparam int IRQ_W      = 12;

    // Port pins: three ports of eight bits
    localparam int PORT_W     = 24;
    localparam int CMD_RST_BIT = 0;

    // Reset values
    localparam logic [FUNC_W-1:0] FUNC_RST = 19'h00000;
    localparam logic [IRQ_W-1:0]  IRQ_RST  = 12'h000;
    localparam logic [PORT_W-1:0] PORT_RST = 24'h000000;

    // Device pin inputs: uart0 tx busy, uart1 tx busy, reset pin level
    localparam int PIN_IN_W   = 3;
    localparam int PIN_U0BUSY = 0;
    localparam int PIN_U1BUSY = 1;
    localparam int PIN_RSTLVL = 2;

    // Reset pulse on the shared reset pin
    localparam int CLK_MHZ       = 125;
    localparam int RST_PULSE_NS  = 1000;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int RST_CNT_W     = 8;

    // Index of port p bit b in the flat port vectors
    function automatic int pin(input int p, input int b);
        return p * 8 + b;
    endfunction : pin

endpackage : mpm_pkg

// file: hw/mpm_sync.sv
`timescale 1ns/1ps
module mpm_sync
(
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          sys_rst,
    input  wire logic                          ce,
    // Pins
    input  wire logic [mpm_pkg::PIN_IN_W-1:0]  d,
    output logic      [mpm_pkg::PIN_IN_W-1:0]  q
);

    logic [mpm_pkg::PIN_IN_W-1:0] s1;
    logic [mpm_pkg::PIN_IN_W-1:0] s2;
    logic [mpm_pkg::PIN_IN_W-1:0] s3;

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q  <= '0;
        end
        else if (ce)
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= (q & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
        end
    end

endmodule : mpm_sync

// file: hw/mpm_guard.sv
`timescale 1ns/1ps
module mpm_guard
(
    // Requests from software
    input  wire logic [mpm_pkg::FUNC_W-1:0]  func_req,
    input  wire logic [mpm_pkg::IRQ_W-1:0]   irq_req,
    input  wire logic [mpm_pkg::PORT_W-1:0]  dir_req,
    input  wire logic [mpm_pkg::PORT_W-1:0]  out_req,
    // Settings safe to apply
    output logic      [mpm_pkg::FUNC_W-1:0]  func_ok,
    output logic      [mpm_pkg::IRQ_W-1:0]   irq_ok,
    output logic      [mpm_pkg::PORT_W-1:0]  dir_ok,
    output logic      [mpm_pkg::PORT_W-1:0]  out_ok
);

    always_comb
    begin
        func_ok = func_req;
        irq_ok  = irq_req;
        dir_ok  = dir_req;
        out_ok  = out_req;
        // SPI loses to decoders 0 and 2 and to the clock output
        if (func_req[mpm_pkg::F_MANCH2] || func_req[mpm_pkg::F_MANCH0]
            || func_req[mpm_pkg::F_SYSTEM_CLOCK_OUT_PIN])
            func_ok[mpm_pkg::F_SPI] = 1'b0; // RULE_03 RULE_18 RULE_19 RULE_20
        // Timer 2 pins belong to decoder 1
        if (func_req[mpm_pkg::F_MANCH1])
        begin
            func_ok[mpm_pkg::F_T2OUT]  = 1'b0; // RULE_08
            func_ok[mpm_pkg::F_T2GATE] = 1'b0; // RULE_08
        end
        // Square wave is lost under JTAG
        if (func_req[mpm_pkg::F_JTAG])
            func_ok[mpm_pkg::F_SQW] = 1'b0; // RULE_13
        // Interrupt lines sharing busy pins
        if (func_req[mpm_pkg::F_MANCH1] || func_ok[mpm_pkg::F_T2GATE])
            irq_ok[3:2] = 2'h0; // RULE_09
        if (func_req[mpm_pkg::F_I2C])
            irq_ok[5:4] = 2'h0; // RULE_10
        if (func_req[mpm_pkg::F_JTAG])
            irq_ok[10:8] = 3'h0; // RULE_14
        if (func_req[mpm_pkg::F_JTAG] || func_ok[mpm_pkg::F_SQW])
            irq_ok[11] = 1'b0; // RULE_14
        if (func_req[mpm_pkg::F_U0FULL])
            irq_ok[0] = 1'b0; // RULE_07
        if (func_req[mpm_pkg::F_U0REN])
            irq_ok[1] = 1'b0; // RULE_07
        if (func_req[mpm_pkg::F_U1FULL])
            irq_ok[6] = 1'b0; // RULE_07
        if (func_req[mpm_pkg::F_U1REN])
            irq_ok[7] = 1'b0; // RULE_07
        // Full-time transmit: output driving 1, idle level between characters
        if (func_req[mpm_pkg::F_U0FULL])
        begin
            dir_ok[mpm_pkg::pin(0, 0)] = 1'b1; // RULE_05 RULE_04
            out_ok[mpm_pkg::pin(0, 0)] = 1'b1; // RULE_05
        end
        if (func_req[mpm_pkg::F_U1FULL])
        begin
            dir_ok[mpm_pkg::pin(0, 6)] = 1'b1; // RULE_05 RULE_04
            out_ok[mpm_pkg::pin(0, 6)] = 1'b1; // RULE_05
        end
        // Timer B pins as inputs
        if (func_req[mpm_pkg::F_TBB_IN])
            dir_ok[mpm_pkg::pin(1, 4)] = 1'b0; // RULE_15
        if (func_req[mpm_pkg::F_TBA_USE])
            dir_ok[mpm_pkg::pin(1, 5)] = 1'b0; // RULE_16
        // Decoder input pins as inputs
        if (func_req[mpm_pkg::F_MANCH0])
        begin
            dir_ok[mpm_pkg::pin(2, 3)] = 1'b0; // RULE_18
            dir_ok[mpm_pkg::pin(2, 4)] = 1'b0; // RULE_18
        end
        if (func_req[mpm_pkg::F_MANCH2])
            dir_ok[mpm_pkg::pin(2, 1)] = 1'b0; // RULE_20
        // JTAG pins are not port pins; keep them undriven by the port
        if (func_req[mpm_pkg::F_JTAG])
            dir_ok[mpm_pkg::pin(1, 3):mpm_pkg::pin(1, 0)] = 4'h0; // RULE_12
    end

endmodule : mpm_guard

// file: hw/mpm_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: one function owns each shared pin
// RULE_02: decoder 2 and SPI off: port drives pin
// RULE_03: never enable decoder 2 with SPI
// RULE_04: UART transmit shows only while sending
// RULE_05: full-time transmit: port output, value 1
// RULE_06: UART receive needs receive-enable bit
// RULE_07: no interrupt on pins used by UART
// RULE_08: decoder 1 excludes timer 2 outputs, gating
// RULE_09: interrupts 2, 3 off with decoder 1/gating
// RULE_10: interrupts 4, 5 off while I2C used
// RULE_11: pulse outputs take pins from port
// RULE_12: JTAG takes port 1 bits 0-3
// RULE_13: JTAG takes away square-wave output
// RULE_14: interrupts 8-11 off under JTAG/square wave; square wave alone turns off only interrupt 11
// RULE_15: timer B secondary input: port1_bit4 input
// RULE_16: timer B primary used: port1_bit5 input
// RULE_17: reset pin low resets unless disabled
// RULE_18: decoder 0: SPI off, two pins input
// RULE_19: clock output enabled makes SPI unusable
// RULE_20: decoder 2: SPI off, port2_bit1 input
// RULE_21: no function enabled: port keeps the pin
module mpm_ctrl
(
    // Clock, reset, enable
    input  wire logic                          clk_sys,
    input  wire logic                          sys_rst,
    input  wire logic                          ce,
    // Software port
    input  wire logic [mpm_pkg::ADDR_W-1:0]    addr,
    input  wire logic [mpm_pkg::DATA_W-1:0]    wdata,
    input  wire logic                          wr,
    input  wire logic                          rd,
    output logic      [mpm_pkg::DATA_W-1:0]    rdata,
    // Device configuration
    output logic      [mpm_pkg::FUNC_W-1:0]    func_en,
    output logic      [mpm_pkg::IRQ_W-1:0]     irq_en,
    output logic      [mpm_pkg::PORT_W-1:0]    port_dir,
    output logic      [mpm_pkg::PORT_W-1:0]    port_out,
    output logic                               reset_pin_disable,
    // Device pins
    input  wire logic [mpm_pkg::PIN_IN_W-1:0]  dev_pins,
    output logic                               rst_pin_out,
    output logic                               rst_pin_oe_n
);

    logic [mpm_pkg::FUNC_W-1:0]    func_req;
    logic [mpm_pkg::IRQ_W-1:0]     irq_req;
    logic [mpm_pkg::PORT_W-1:0]    dir_req;
    logic [mpm_pkg::PORT_W-1:0]    out_req;
    logic [mpm_pkg::FUNC_W-1:0]    func_ok;
    logic [mpm_pkg::IRQ_W-1:0]     irq_ok;
    logic [mpm_pkg::PORT_W-1:0]    dir_ok;
    logic [mpm_pkg::PORT_W-1:0]    out_ok;
    logic [mpm_pkg::FUNC_W-1:0]    func_ref;
    logic [mpm_pkg::IRQ_W-1:0]     irq_ref;
    logic [mpm_pkg::PIN_IN_W-1:0]  pins_s;
    logic [mpm_pkg::RST_CNT_W-1:0] rst_cnt;
    logic [mpm_pkg::DATA_W-1:0]    next_rdata;
    logic                          rst_go;

    mpm_guard u_guard
    (
        .func_req (func_req),
        .irq_req  (irq_req),
        .dir_req  (dir_req),
        .out_req  (out_req),
        .func_ok  (func_ok),
        .irq_ok   (irq_ok),
        .dir_ok   (dir_ok),
        .out_ok   (out_ok)
    );

    mpm_sync u_sync
    (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .d        (dev_pins),
        .q        (pins_s)
    );

    assign rst_go = ce && wr && addr == mpm_pkg::OFF_COMMAND
                    && wdata[mpm_pkg::CMD_RST_BIT];

    // Requested settings
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            func_req <= mpm_pkg::FUNC_RST;
            irq_req  <= mpm_pkg::IRQ_RST;
            dir_req  <= mpm_pkg::PORT_RST;
            out_req  <= mpm_pkg::PORT_RST;
        end
        else if (ce && wr)
        begin
            case (addr)
                mpm_pkg::OFF_FUNC_REQ: func_req <= wdata[mpm_pkg::FUNC_W-1:0];
                mpm_pkg::OFF_IRQ_REQ:  irq_req  <= wdata[mpm_pkg::IRQ_W-1:0];
                mpm_pkg::OFF_PORT_DIR: dir_req  <= wdata[mpm_pkg::PORT_W-1:0];
                mpm_pkg::OFF_PORT_OUT: out_req  <= wdata[mpm_pkg::PORT_W-1:0];
                default: ;
            endcase
        end
    end

    // Applied settings; port settings pass through where no function claims the pin
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            func_en           <= mpm_pkg::FUNC_RST;
            irq_en            <= mpm_pkg::IRQ_RST;
            port_dir          <= mpm_pkg::PORT_RST;
            port_out          <= mpm_pkg::PORT_RST;
            reset_pin_disable <= 1'b0;
        end
        else if (ce)
        begin
            func_en           <= func_ok; // RULE_01 RULE_06 RULE_11
            irq_en            <= irq_ok;
            port_dir          <= dir_ok; // RULE_02 RULE_21
            port_out          <= out_ok; // RULE_21
            reset_pin_disable <= func_ok[mpm_pkg::F_RESET_PIN_DISABLE]; // RULE_17
        end
    end

    // Refused requests, sticky; write 1 clears, a new refusal wins
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            func_ref <= mpm_pkg::FUNC_RST;
            irq_ref  <= mpm_pkg::IRQ_RST;
        end
        else if (ce)
        begin
            func_ref <= (func_ref & ~((wr && addr == mpm_pkg::OFF_FUNC_REF)
                        ? wdata[mpm_pkg::FUNC_W-1:0] : mpm_pkg::FUNC_RST))
                        | (func_req & ~func_ok); // RULE_01
            irq_ref  <= (irq_ref & ~((wr && addr == mpm_pkg::OFF_IRQ_REF)
                        ? wdata[mpm_pkg::IRQ_W-1:0] : mpm_pkg::IRQ_RST))
                        | (irq_req & ~irq_ok);
        end
    end

    // Device reset pulse on the open-drain reset pin
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rst_cnt      <= '0;
            rst_pin_out  <= 1'b0;
            rst_pin_oe_n <= 1'b1;
        end
        else if (ce)
        begin
            if (rst_go && rst_cnt == '0 && rst_pin_oe_n && !reset_pin_disable)
            begin
                rst_cnt      <= mpm_pkg::RST_CNT_W'(mpm_pkg::RST_PULSE_CYC - 1);
                rst_pin_oe_n <= 1'b0; // RULE_17
            end
            else if (rst_cnt != '0)
                rst_cnt <= rst_cnt - 1'b1;
            else
                rst_pin_oe_n <= 1'b1;
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_comb
    begin
        next_rdata = '0;
        case (addr)
            mpm_pkg::OFF_FUNC_REQ: next_rdata[mpm_pkg::FUNC_W-1:0]  = func_req;
            mpm_pkg::OFF_IRQ_REQ:  next_rdata[mpm_pkg::IRQ_W-1:0]   = irq_req;
            mpm_pkg::OFF_PORT_DIR: next_rdata[mpm_pkg::PORT_W-1:0]  = dir_req;
            mpm_pkg::OFF_PORT_OUT: next_rdata[mpm_pkg::PORT_W-1:0]  = out_req;
            mpm_pkg::OFF_FUNC_REF: next_rdata[mpm_pkg::FUNC_W-1:0]  = func_ref;
            mpm_pkg::OFF_IRQ_REF:  next_rdata[mpm_pkg::IRQ_W-1:0]   = irq_ref;
            mpm_pkg::OFF_COMMAND:  next_rdata[mpm_pkg::CMD_RST_BIT] = !rst_pin_oe_n;
            mpm_pkg::OFF_PIN_STAT: next_rdata[mpm_pkg::PIN_IN_W-1:0] = pins_s;
            default:               next_rdata = '0;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            rdata <= '0;
        else if (ce)
            rdata <= rd ? next_rdata : '0;
    end

    // Checks
    localparam int RST_CYC_A = mpm_pkg::RST_PULSE_CYC;
    localparam int RST_TAIL_A = RST_CYC_A - 8;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst || !ce);

    sequence s_rst_start;
        rst_go && rst_cnt == '0 && rst_pin_oe_n && !reset_pin_disable;
    endsequence

    sequence s_rst_held;
        (!rst_pin_oe_n && !rst_pin_out)[*8];
    endsequence

    sequence s_rst_tail;
        !rst_pin_oe_n ##1 rst_pin_oe_n;
    endsequence

    spi_exclusion_a: assert property (func_en[mpm_pkg::F_SPI] |-> !func_en[mpm_pkg::F_MANCH2] // RULE_03
        && !func_en[mpm_pkg::F_MANCH0] && !func_en[mpm_pkg::F_SYSTEM_CLOCK_OUT_PIN])
        else $error("SPI applied beside a decoder or clock output");

    timer2_guard_a: assert property (func_en[mpm_pkg::F_MANCH1] |-> // RULE_08
        !func_en[mpm_pkg::F_T2OUT] && !func_en[mpm_pkg::F_T2GATE])
        else $error("Timer 2 enabled with decoder 1");

    irq_two_three_a: assert property ((func_en[mpm_pkg::F_MANCH1] // RULE_09
        || func_en[mpm_pkg::F_T2GATE]) |-> irq_en[3:2] == 2'h0)
        else $error("Interrupt 2 or 3 enabled on busy pin");

    irq_i2c_a: assert property (func_en[mpm_pkg::F_I2C] |-> irq_en[5:4] == 2'h0) // RULE_10
        else $error("Interrupt 4 or 5 enabled with I2C");

    irq_jtag_a: assert property ((func_en[mpm_pkg::F_JTAG] || func_en[mpm_pkg::F_SQW]) // RULE_14
        |-> !irq_en[11] && (!func_en[mpm_pkg::F_JTAG] || irq_en[10:8] == 3'h0))
        else $error("Interrupt 8 to 11 enabled under JTAG or square wave");

    uart_full_a: assert property (func_req[mpm_pkg::F_U0FULL] |=> // RULE_05
        port_dir[mpm_pkg::pin(0, 0)] && port_out[mpm_pkg::pin(0, 0)] && !irq_en[0])
        else $error("Full-time transmit pin not set to output 1");

    timer_b_dir_a: assert property (func_en[mpm_pkg::F_TBB_IN] |-> // RULE_15
        !port_dir[mpm_pkg::pin(1, 4)])
        else $error("Timer B secondary pin not input");

    timer_b_pri_a: assert property (func_en[mpm_pkg::F_TBA_USE] |-> // RULE_16
        !port_dir[mpm_pkg::pin(1, 5)])
        else $error("Timer B primary pin not input");

    decoder_dir_a: assert property ((func_en[mpm_pkg::F_MANCH0] |-> // RULE_18
        !port_dir[mpm_pkg::pin(2, 3)] && !port_dir[mpm_pkg::pin(2, 4)])
        and (func_en[mpm_pkg::F_MANCH2] |-> !port_dir[mpm_pkg::pin(2, 1)]))
        else $error("Decoder input pin left as output");

    reset_pulse_a: assert property (s_rst_start |=> s_rst_held // RULE_17
        ##RST_TAIL_A s_rst_tail)
        else $error("Reset pin pulse wrong length");

    reset_blocked_a: assert property ((rst_go && reset_pin_disable && rst_pin_oe_n) // RULE_17
        |=> rst_pin_oe_n)
        else $error("Reset pulse driven while reset pin disabled");

    refused_flag_a: assert property ((func_req != func_ok) |=> // RULE_01
        (func_ref & $past(func_req & ~func_ok)) == $past(func_req & ~func_ok))
        else $error("Refused request not flagged");

    irq_refused_a: assert property ((irq_req != irq_ok) |=> // RULE_07
        (irq_ref & $past(irq_req & ~irq_ok)) == $past(irq_req & ~irq_ok))
        else $error("Refused interrupt not flagged");

    uart1_full_a: assert property (func_req[mpm_pkg::F_U1FULL] |=> // RULE_05
        port_dir[mpm_pkg::pin(0, 6)] && port_out[mpm_pkg::pin(0, 6)] && !irq_en[6])
        else $error("Second full-time transmit pin not set to output 1");

    uart_rx_irq_a: assert property ((func_en[mpm_pkg::F_U0REN] |-> !irq_en[1]) // RULE_07
        and (func_en[mpm_pkg::F_U1REN] |-> !irq_en[7]))
        else $error("Interrupt enabled on a receive pin");

    jtag_port_a: assert property (func_en[mpm_pkg::F_JTAG] |-> // RULE_12
        port_dir[mpm_pkg::pin(1, 3):mpm_pkg::pin(1, 0)] == 4'h0)
        else $error("Port drives a JTAG pin");

    sqw_lost_a: assert property (func_en[mpm_pkg::F_JTAG] |-> // RULE_13
        !func_en[mpm_pkg::F_SQW])
        else $error("Square wave applied under JTAG");

    gpio_pass_a: assert property ((!func_req[mpm_pkg::F_MANCH2] // RULE_02
        && !func_req[mpm_pkg::F_SPI]) |=> port_dir[mpm_pkg::pin(2, 0)]
        == $past(dir_req[mpm_pkg::pin(2, 0)]))
        else $error("Shared decoder pin not left to the port");

    port_pass_a: assert property (func_req == mpm_pkg::FUNC_RST |=> // RULE_21
        port_dir == $past(dir_req) && port_out == $past(out_req))
        else $error("Port settings not passed through");

    pulse_pass_a: assert property ((func_req[mpm_pkg::F_PULSE1] // RULE_11
        |=> func_en[mpm_pkg::F_PULSE1]) and (func_req[mpm_pkg::F_PULSE2]
        |=> func_en[mpm_pkg::F_PULSE2]))
        else $error("Pulse output not applied");

    cmd_status_a: assert property ((rd && addr == mpm_pkg::OFF_COMMAND) |=> // RULE_17
        rdata[mpm_pkg::CMD_RST_BIT] == !$past(rst_pin_oe_n))
        else $error("Reset pulse status misread");

    rst_dis_a: assert property (reset_pin_disable == func_en[mpm_pkg::F_RESET_PIN_DISABLE]) // RULE_17
        else $error("Reset pin disable not applied");

endmodule : mpm_ctrl

// file: test/mpm_dev_model.sv
`timescale 1ns/1ps
module mpm_dev_model
(
    // Clock
    input  wire logic                         clk_sys,
    // Controller side
    input  wire logic                         reset_pin_disable,
    input  wire logic                         rst_pin_out,
    input  wire logic                         rst_pin_oe_n,
    // Transmit start per channel
    input  wire logic [1:0]                   tx_go,
    // Device pins
    output logic      [mpm_pkg::PIN_IN_W-1:0] dev_pins,
    output logic                              dev_reset
);
    logic [3:0] busy0 = 4'h0;
    logic [3:0] busy1 = 4'h0;
    logic       rst_lvl;
    // Pull-up holds the reset pin high when released
    assign rst_lvl   = rst_pin_oe_n ? 1'b1 : rst_pin_out;
    assign dev_reset = !rst_lvl && !reset_pin_disable;
    // Transmitter busy only while a character is sent
    always_ff @(posedge clk_sys)
    begin
        busy0 <= tx_go[0] ? 4'hA : busy0 - {3'h0, busy0 != 4'h0};
        busy1 <= tx_go[1] ? 4'hA : busy1 - {3'h0, busy1 != 4'h0};
    end
    assign dev_pins = {rst_lvl, busy1 != 4'h0, busy0 != 4'h0};
endmodule : mpm_dev_model

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
    logic                         clk_sys = 1'b0;
    logic                         sys_rst = 1'b1;
    logic                         ce = 1'b1;
    logic [mpm_pkg::ADDR_W-1:0]   addr = 8'h00;
    logic [mpm_pkg::DATA_W-1:0]   wdata = 32'h0;
    logic                         wr = 1'b0;
    logic                         rd = 1'b0;
    logic [1:0]                   tx_go = 2'h0;
    logic [mpm_pkg::DATA_W-1:0]   rdata;
    logic [mpm_pkg::FUNC_W-1:0]   func_en;
    logic [mpm_pkg::IRQ_W-1:0]    irq_en;
    logic [mpm_pkg::PORT_W-1:0]   port_dir;
    logic [mpm_pkg::PORT_W-1:0]   port_out;
    logic                         reset_pin_disable;
    logic [mpm_pkg::PIN_IN_W-1:0] dev_pins;
    logic                         rst_pin_out;
    logic                         rst_pin_oe_n;
    logic                         dev_reset;
    int                           errors = 0;
    int                           compares = 0;

    always #4 clk_sys = ~clk_sys;

    mpm_ctrl dut (.clk_sys, .sys_rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .func_en, .irq_en,
        .port_dir, .port_out, .reset_pin_disable, .dev_pins, .rst_pin_out, .rst_pin_oe_n);

    mpm_dev_model dev (.clk_sys, .reset_pin_disable, .rst_pin_out, .rst_pin_oe_n, .tx_go,
        .dev_pins, .dev_reset);

    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask : rd_chk

    task automatic apply(input logic [31:0] f, i, d, o);
        wr_reg(mpm_pkg::OFF_FUNC_REQ, f);
        wr_reg(mpm_pkg::OFF_IRQ_REQ, i);
        wr_reg(mpm_pkg::OFF_PORT_DIR, d);
        wr_reg(mpm_pkg::OFF_PORT_OUT, o);
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : apply

    task automatic clear_ref();
        apply(32'h0, 32'h0, 32'h0, 32'h0);
        wr_reg(mpm_pkg::OFF_FUNC_REF, 32'hFFFFFFFF);
        wr_reg(mpm_pkg::OFF_IRQ_REF, 32'hFFFFFFFF);
        rd_chk("func_refused", mpm_pkg::OFF_FUNC_REF, 32'h0);
        rd_chk("irq_refused", mpm_pkg::OFF_IRQ_REF, 32'h0);
    endtask : clear_ref

    task automatic t_reset();
        chk("oe_n", 32'h1, rst_pin_oe_n);
        for (int a = 0; a < 9; a++)
            rd_chk("reg", 8'(a * 4), (a == 7) ? 32'h4 : 32'h0);
    endtask : t_reset

    task automatic t_pass();
        for (int b = 0; b < mpm_pkg::FUNC_W; b++)
        begin
            apply(32'h1 << b, 32'h0, 32'h0, 32'h0);
            chk("func_en", 32'h1 << b, func_en);
        end
        chk("rst_dis", 32'h1, reset_pin_disable);
        apply(32'h0, 32'hFFF, 32'h00A5C3, 32'h003C5A);
        chk("irq_en", 32'hFFF, irq_en);
        chk("port_dir", 32'h00A5C3, port_dir);
        chk("port_out", 32'h003C5A, port_out);
    endtask : t_pass

    task automatic t_conflict();
        int w [6] = '{mpm_pkg::F_MANCH2, mpm_pkg::F_MANCH0, mpm_pkg::F_SYSTEM_CLOCK_OUT_PIN,
                      mpm_pkg::F_MANCH1, mpm_pkg::F_MANCH1, mpm_pkg::F_JTAG};
        int l [6] = '{mpm_pkg::F_SPI, mpm_pkg::F_SPI, mpm_pkg::F_SPI,
                      mpm_pkg::F_T2OUT, mpm_pkg::F_T2GATE, mpm_pkg::F_SQW};
        for (int k = 0; k < 6; k++)
        begin
            apply((32'h1 << w[k]) | (32'h1 << l[k]), 32'h0, 32'h0, 32'h0);
            chk("func_en", 32'h1 << w[k], func_en);
            rd_chk("func_refused", mpm_pkg::OFF_FUNC_REF, 32'h1 << l[k]);
            clear_ref();
        end
    endtask : t_conflict

    task automatic t_irq();
        int          f [9] = '{mpm_pkg::F_I2C, mpm_pkg::F_MANCH1, mpm_pkg::F_T2GATE,
                               mpm_pkg::F_JTAG, mpm_pkg::F_SQW, mpm_pkg::F_U0REN,
                               mpm_pkg::F_U1REN, mpm_pkg::F_U0FULL, mpm_pkg::F_U1FULL};
        logic [11:0] m [9] = '{12'h030, 12'h00C, 12'h00C, 12'hF00, 12'h800,
                               12'h002, 12'h080, 12'h001, 12'h040};
        for (int k = 0; k < 9; k++)
        begin
            apply(32'h1 << f[k], 32'hFFF, 32'h0, 32'h0);
            chk("irq_en", {20'h0, ~m[k]}, irq_en);
            rd_chk("irq_refused", mpm_pkg::OFF_IRQ_REF, {20'h0, m[k]});
            clear_ref();
        end
    endtask : t_irq

    task automatic t_port();
        int          f [7] = '{mpm_pkg::F_U0FULL, mpm_pkg::F_U1FULL, mpm_pkg::F_TBB_IN,
                               mpm_pkg::F_TBA_USE, mpm_pkg::F_MANCH0, mpm_pkg::F_MANCH2,
                               mpm_pkg::F_JTAG};
        logic [23:0] s [7] = '{24'h000001, 24'h000040, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0};
        logic [23:0] c [7] = '{24'h0, 24'h0, 24'h001000, 24'h002000, 24'h180000,
                               24'h020000, 24'h000F00};
        logic [23:0] r;
        for (int k = 0; k < 14; k++)
        begin
            r = (k % 2 == 1) ? 24'hFFFFFF : 24'h000000;
            apply(32'h1 << f[k / 2], 32'h0, {8'h0, r}, {8'h0, ~r});
            chk("port_dir", {8'h0, (r | s[k / 2]) & ~c[k / 2]}, port_dir);
            chk("port_out", {8'h0, ~r | s[k / 2]}, port_out);
        end
    endtask : t_port

    task automatic t_pins();
        @(posedge clk_sys);
        tx_go <= 2'h3;
        @(posedge clk_sys);
        tx_go <= 2'h0;
        repeat (4) @(posedge clk_sys);
        rd_chk("pin_status", mpm_pkg::OFF_PIN_STAT, 32'h7);
        repeat (20) @(posedge clk_sys);
        rd_chk("pin_status", mpm_pkg::OFF_PIN_STAT, 32'h4);
    endtask : t_pins

    task automatic t_hold();
        @(posedge clk_sys);
        ce <= 1'b0;
        wr_reg(mpm_pkg::OFF_FUNC_REQ, 32'h1 << mpm_pkg::F_I2C);
        repeat (3) @(posedge clk_sys);
        ce <= 1'b1;
        #1;
        chk("func_en", 32'h1 << mpm_pkg::F_JTAG, func_en);
        rd_chk("func_req", mpm_pkg::OFF_FUNC_REQ, 32'h1 << mpm_pkg::F_JTAG);
    endtask : t_hold

    task automatic t_pulse();
        int   n = 0;
        logic seen = 1'b0;
        apply(32'h0, 32'h0, 32'h0, 32'h0);
        wr_reg(mpm_pkg::OFF_COMMAND, 32'h1);
        #1;
        while (rst_pin_oe_n === 1'b0 && n < 300)
        begin
            n++;
            seen |= dev_reset;
            @(posedge clk_sys);
            #1;
        end
        chk("pulse_len", mpm_pkg::RST_PULSE_CYC, n);
        chk("dev_reset", 32'h1, seen);
        if (n == 300)
            give_verdict();
        apply(32'h1 << mpm_pkg::F_RESET_PIN_DISABLE, 32'h0, 32'h0, 32'h0);
        wr_reg(mpm_pkg::OFF_COMMAND, 32'h1);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("oe_n", 32'h1, rst_pin_oe_n);
    endtask : t_pulse

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        give_verdict();
    end

    initial
    begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_pass();
        t_conflict();
        t_irq();
        t_port();
        t_pins();
        t_hold();
        t_pulse();
        give_verdict();
    end
endmodule : tb
